// File: design/tblp_regs.vh
`ifndef TBLP_REGS_VH
`define TBLP_REGS_VH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define TBLP_IDX_MODE      16'hffa6
`define TBLP_IDX_COUNT     16'hffa7
`define TBLP_IDX_A_DATA    16'hffda
`define TBLP_IDX_B_DATA    16'hffdb
`define TBLP_IDX_A_DIR     16'hffea
`define TBLP_IDX_B_DIR     16'hffeb
`define TBLP_IDX_IRQ_EN    16'hfff4
`define TBLP_IDX_IRQ_REQ   16'hfff6

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define TBLP_BIT_LED_ONE   4
`define TBLP_BIT_LED_TWO   7
`define TBLP_BIT_TIMER_IRQ 6
`define TBLP_MODE_MASK     8'h0f
`define TBLP_MODE_TIMEBASE 8'h09
`define TBLP_RST_BYTE      8'h00
`define TBLP_CNT_MAX       8'hff
`define TBLP_SUB_DIV_LAST  2'h3
`define TBLP_PRE_WIDTH     5
`define TBLP_PRE_TAP       3
`define TBLP_ADDR_WIDTH    18

`endif

// File: design/tblp_top.v
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "tblp_regs.vh"

module tblp_top #(
  parameter PRE_TAP = `TBLP_PRE_TAP
) (
  input  wire                        CLK_SYS,
  input  wire                        SYS_RST,
  input  wire                        PSEL,
  input  wire                        PENABLE,
  input  wire                        PWRITE,
  input  wire [`TBLP_ADDR_WIDTH-1:0] PADDR,
  input  wire [31:0]                 PWDATA,
  output reg  [31:0]                 PRDATA,
  output reg                         PREADY,
  output reg                         PSLVERR,
  input  wire                        SUBCLK,
  input  wire                        LED_ONE_IN,
  output reg                         LED_ONE_OUT,
  output reg                         LED_ONE_OE_N,
  input  wire                        LED_TWO_IN,
  output reg                         LED_TWO_OUT,
  output reg                         LED_TWO_OE_N,
  output reg                         TIMER_IRQ
);

  // ----------------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------------

  // Byte address of a register from its index, used by every decode.
  function [`TBLP_ADDR_WIDTH-1:0] byte_addr;
    input [15:0] idx;
    begin
      byte_addr = {idx, 2'b00};
    end
  endfunction

  // Zero-extends one register byte into a bus word.
  function [31:0] word_of;
    input [7:0] b;
    begin
      word_of = {24'h000000, b};
    end
  endfunction

  // True when the bus address selects the register with this index.
  function addr_hit;
    input [`TBLP_ADDR_WIDTH-1:0] addr;
    input [15:0]                 idx;
    begin
      addr_hit = (addr == byte_addr(idx));
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [7:0]                 mode_reg;
  reg [7:0]                 count_reg;
  reg [7:0]                 a_data_reg;
  reg [7:0]                 b_data_reg;
  reg [7:0]                 a_dir_reg;
  reg [7:0]                 b_dir_reg;
  reg [7:0]                 irq_en_reg;
  reg [7:0]                 irq_req_reg;
  reg [2:0]                 sub_sync_reg;
  reg [1:0]                 sub_div_reg;
  reg [`TBLP_PRE_WIDTH-1:0] pre_reg;
  reg [1:0]                 one_sync_reg;
  reg [1:0]                 two_sync_reg;

  wire sub_rise;
  wire sub_tick;
  wire pre_tap_now;
  wire pre_tap_next;
  wire timebase_on;
  wire count_tick;
  wire overflow;
  wire access;
  wire wr_go;
  wire wr_mode;
  wire wr_a_data;
  wire wr_b_data;
  wire wr_a_dir;
  wire wr_b_dir;
  wire wr_irq_en;
  wire wr_irq_req;

  // Prescaler value one step on, used to spot its tapped bit falling.
  wire [`TBLP_PRE_WIDTH-1:0] pre_plus;

  // Sub-clock edge seen on the second and third stages only, never the
  // first, so a metastable first stage cannot leak into the dividers.
  assign sub_rise     = sub_sync_reg[1] & ~sub_sync_reg[2];
  assign sub_tick     = sub_rise & (sub_div_reg == `TBLP_SUB_DIV_LAST);
  // The next prescaler value is worked out whole, so every tap from
  // zero up is decoded the same way.
  assign pre_plus     = pre_reg + {{(`TBLP_PRE_WIDTH-1){1'b0}}, 1'b1};
  assign pre_tap_now  = pre_reg[PRE_TAP];
  assign pre_tap_next = pre_plus[PRE_TAP];
  // Prescaler output falls once per full cycle of its tapped bit.
  // Only the time-base mode is built; any other value in the low four mode bits leaves the
  // counter holding its count rather than stepping at a wrong rate.
  assign timebase_on  =
    ((mode_reg & `TBLP_MODE_MASK) == `TBLP_MODE_TIMEBASE);
  assign count_tick   = sub_tick & pre_tap_now & ~pre_tap_next &
                        timebase_on;
  assign overflow     = count_tick & (count_reg == `TBLP_CNT_MAX);

  // Bus handshake: the access cycle waits one cycle for the registered
  // ready, which keeps every bus output straight from a flip-flop.
  // Every transfer therefore takes three clocks, setup included.
  assign access = PSEL & PENABLE;
  assign wr_go  = access & PREADY & PWRITE;

  // One strobe per writable register, live only at the committing edge,
  // so a register never takes the data of a transfer still in setup.
  assign wr_mode    = wr_go & addr_hit(PADDR, `TBLP_IDX_MODE);
  assign wr_a_data  = wr_go & addr_hit(PADDR, `TBLP_IDX_A_DATA);
  assign wr_b_data  = wr_go & addr_hit(PADDR, `TBLP_IDX_B_DATA);
  assign wr_a_dir   = wr_go & addr_hit(PADDR, `TBLP_IDX_A_DIR);
  assign wr_b_dir   = wr_go & addr_hit(PADDR, `TBLP_IDX_B_DIR);
  assign wr_irq_en  = wr_go & addr_hit(PADDR, `TBLP_IDX_IRQ_EN);
  assign wr_irq_req = wr_go & addr_hit(PADDR, `TBLP_IDX_IRQ_REQ);

  // ----------------------------------------------------------------------
  // Synchronisers, dividers and timer counter
  // ----------------------------------------------------------------------

  // Sub-clock divided by four feeds the five-bit prescaler. The
  // sub-clock is sampled, not used as a clock, so the whole block stays
  // in one clock domain; the price is that the system clock must run
  // well above the sub-clock rate for no edge to be missed. The
  // prescaler runs in every mode; only the counter stops.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      sub_sync_reg <= 3'h0;
      sub_div_reg  <= 2'h0;
      pre_reg      <= {`TBLP_PRE_WIDTH{1'b0}};
      one_sync_reg <= 2'h0;
      two_sync_reg <= 2'h0;
      count_reg    <= `TBLP_RST_BYTE;
    end else begin
      sub_sync_reg <= {sub_sync_reg[1:0], SUBCLK};
      one_sync_reg <= {one_sync_reg[0], LED_ONE_IN};
      two_sync_reg <= {two_sync_reg[0], LED_TWO_IN};
      if (sub_rise) begin
        sub_div_reg <= sub_div_reg + 2'h1;
      end
      if (sub_tick) begin
        pre_reg <= pre_plus;
      end
      if (count_tick) begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // Software registers; the counter itself is read only.
  // A write to the counter address is taken without error and dropped.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_reg   <= `TBLP_RST_BYTE;
      a_data_reg <= `TBLP_RST_BYTE;
      b_data_reg <= `TBLP_RST_BYTE;
      a_dir_reg  <= `TBLP_RST_BYTE;
      b_dir_reg  <= `TBLP_RST_BYTE;
      irq_en_reg <= `TBLP_RST_BYTE;
    end else begin
      if (wr_mode) begin
        mode_reg <= PWDATA[7:0];
      end
      if (wr_a_data) begin
        a_data_reg <= PWDATA[7:0];
      end
      if (wr_b_data) begin
        b_data_reg <= PWDATA[7:0];
      end
      if (wr_a_dir) begin
        a_dir_reg <= PWDATA[7:0];
      end
      if (wr_b_dir) begin
        b_dir_reg <= PWDATA[7:0];
      end
      if (wr_irq_en) begin
        irq_en_reg <= PWDATA[7:0];
      end
    end
  end

  // Request flags: writing zero clears, writing one leaves a bit alone.
  // An overflow in the same cycle as the clear wins, so none is lost.
  // Bits other than the timer one have no source in this block and can
  // only be cleared, so after reset they always read zero.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_req_reg <= `TBLP_RST_BYTE;
    end else begin
      if (wr_irq_req) begin
        irq_req_reg <= irq_req_reg & PWDATA[7:0];
      end
      if (overflow) begin
        irq_req_reg[`TBLP_BIT_TIMER_IRQ] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data and bus answer
  // ----------------------------------------------------------------------
  reg [7:0]  a_view;
  reg [7:0]  b_view;
  reg [31:0] rdata_next;
  reg        err_next;

  // Port views replace the pin bit by its level while it is an input.
  // The level seen here is two system clocks old, the cost of the
  // synchroniser; a read straight after a pin change may still show
  // the earlier level.
  always @* begin
    a_view = a_data_reg;
    b_view = b_data_reg;
    if (!a_dir_reg[`TBLP_BIT_LED_ONE]) begin
      a_view[`TBLP_BIT_LED_ONE] = one_sync_reg[1];
    end
    if (!b_dir_reg[`TBLP_BIT_LED_TWO]) begin
      b_view[`TBLP_BIT_LED_TWO] = two_sync_reg[1];
    end
    err_next = 1'b0;
    case (PADDR)
      byte_addr(`TBLP_IDX_MODE):    rdata_next = word_of(mode_reg);
      byte_addr(`TBLP_IDX_COUNT):   rdata_next = word_of(count_reg);
      byte_addr(`TBLP_IDX_A_DATA):  rdata_next = word_of(a_view);
      byte_addr(`TBLP_IDX_B_DATA):  rdata_next = word_of(b_view);
      byte_addr(`TBLP_IDX_A_DIR):   rdata_next = word_of(a_dir_reg);
      byte_addr(`TBLP_IDX_B_DIR):   rdata_next = word_of(b_dir_reg);
      byte_addr(`TBLP_IDX_IRQ_EN):  rdata_next = word_of(irq_en_reg);
      byte_addr(`TBLP_IDX_IRQ_REQ): rdata_next = word_of(irq_req_reg);
      default: begin
        rdata_next = 32'h00000000;
        err_next   = 1'b1; // Unmapped address answers with an error.
      end
    endcase
  end

  // Ready rises one cycle into the access phase and drops after it.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY <= access & ~PREADY;
      if (access && !PREADY) begin
        PSLVERR <= err_next;
        PRDATA  <= PWRITE ? 32'h00000000 : rdata_next;
      end else begin
        PSLVERR <= 1'b0;
        PRDATA  <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pins and interrupt output
  // ----------------------------------------------------------------------

  // Pin drivers and the gated interrupt, all registered. Each lags its
  // register by one clock, which keeps decode glitches off the pins at
  // the cost of that one cycle of latency.
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      LED_ONE_OUT  <= 1'b0;
      LED_ONE_OE_N <= 1'b1;
      LED_TWO_OUT  <= 1'b0;
      LED_TWO_OE_N <= 1'b1;
      TIMER_IRQ    <= 1'b0;
    end else begin
      LED_ONE_OUT  <= a_data_reg[`TBLP_BIT_LED_ONE];
      LED_ONE_OE_N <= ~a_dir_reg[`TBLP_BIT_LED_ONE];
      LED_TWO_OUT  <= b_data_reg[`TBLP_BIT_LED_TWO];
      LED_TWO_OE_N <= ~b_dir_reg[`TBLP_BIT_LED_TWO];
      TIMER_IRQ    <= irq_req_reg[`TBLP_BIT_TIMER_IRQ] &
                      irq_en_reg[`TBLP_BIT_TIMER_IRQ];
    end
  end

endmodule

// File: dv/tblp_props.sv
`timescale 1ns/1ps
module tblp_props #(
  parameter PRE_TAP = 3
) (
  input wire        CLK_SYS,
  input wire        SYS_RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [17:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        LED_ONE_OUT,
  input wire        LED_TWO_OE_N,
  input wire        TIMER_IRQ
);
  // ----
  // Bus and pin checks
  // ----
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // A write commits where the access phase meets ready.
  wire wr = PSEL && PENABLE && PREADY && PWRITE;
  // Writes to the interrupt enable or request register only.
  wire irq_wr = wr && (PADDR == 18'h3ffd0 || PADDR == 18'h3ffd8);
  chk_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  chk_err_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error without ready or with data");
  // Checked two edges on, since the pin stage is registered after the store.
  chk_led_level: assert property (wr && PADDR == 18'h3ff68 |-> ##2
    LED_ONE_OUT == $past(PWDATA[4], 2)) else $error("pin one level");
  chk_led_dir: assert property (wr && PADDR == 18'h3ffac |-> ##2
    LED_TWO_OE_N == !$past(PWDATA[7], 2)) else $error("pin two enable");
  chk_irq_gated: assert property (wr && PADDR == 18'h3ffd0
    && !PWDATA[6] |-> ##2 !TIMER_IRQ) else $error("interrupt not gated");
  chk_irq_sticky: assert property ($fell(TIMER_IRQ) |-> $past(irq_wr, 2))
    else $error("interrupt dropped without a write");
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "tblp_regs.vh"
module tb;
  logic        CLK_SYS = 0;
  logic        SYS_RST = 1;
  logic        PSEL = 0;
  logic        PENABLE = 0;
  logic        PWRITE = 0;
  logic [17:0] PADDR = 0;
  logic [31:0] PWDATA = 0;
  logic        SUBCLK = 0;
  logic        LED_ONE_IN = 0;
  logic        LED_TWO_IN = 0;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, TIMER_IRQ;
  wire         LED_ONE_OUT, LED_ONE_OE_N, LED_TWO_OUT, LED_TWO_OE_N;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  logic [31:0] seed = 32'd88;
  logic [31:0] q;
  logic        e;
  logic [7:0]  da, db, ra, rb;
  logic [2:0]  sub_cnt = 0;
  logic [15:0] idx [8] = '{`TBLP_IDX_MODE, `TBLP_IDX_COUNT,
    `TBLP_IDX_A_DATA, `TBLP_IDX_B_DATA, `TBLP_IDX_A_DIR,
    `TBLP_IDX_B_DIR, `TBLP_IDX_IRQ_EN, `TBLP_IDX_IRQ_REQ};

  // Tap 0 makes an overflow eight times sooner than the real divider.
  tblp_top #(.PRE_TAP(0)) i_dut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SUBCLK(SUBCLK), .LED_ONE_IN(LED_ONE_IN), .LED_ONE_OUT(LED_ONE_OUT),
    .LED_ONE_OE_N(LED_ONE_OE_N), .LED_TWO_IN(LED_TWO_IN),
    .LED_TWO_OUT(LED_TWO_OUT), .LED_TWO_OE_N(LED_TWO_OE_N),
    .TIMER_IRQ(TIMER_IRQ));

  always #12.5 CLK_SYS = ~CLK_SYS;
  // Sub-clock at an eighth of the system rate, plus the hang guard.
  always @(posedge CLK_SYS) begin
    sub_cnt <= sub_cnt + 3'h1;
    SUBCLK  <= sub_cnt[2];
    cycles  <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end

  // ----
  // Helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Output bits read back as stored, the input bit as the pin.
  function automatic logic [31:0] port_exp(input logic [7:0] d,
    input logic [7:0] r, input int b, input logic pin);
    d[b] = r[b] ? d[b] : pin;
    return {24'h0, d};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] ix,
    input logic [7:0] d);
    logic [31:0] r;
    r = xs();
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {ix, 2'b00};
    PWDATA <= {r[31:8], d};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // Waits for ready however long it takes; a hang ends at the ceiling.
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (4) @(posedge CLK_SYS);
    SYS_RST <= 1'b0;
    foreach (idx[i]) begin
      bus(0, idx[i], 8'h0);
      chk(q, 0);
    end
    chk(LED_ONE_OE_N, 1);
    // Unmapped place errs; counter writes are quietly dropped.
    bus(1, 16'h0100, 8'h5a);
    chk(e, 1);
    bus(1, `TBLP_IDX_COUNT, 8'h33);
    chk(e, 0);
    bus(0, `TBLP_IDX_COUNT, 8'h0);
    chk(q, 0);
    for (int k = 0; k < 8; k++) begin
      q = xs();
      LED_ONE_IN <= q[0];
      LED_TWO_IN <= q[1];
      {da, db, ra} = q[31:8];
      rb = ra ^ q[7:0];
      bus(1, `TBLP_IDX_A_DATA, da);
      bus(1, `TBLP_IDX_B_DATA, db);
      bus(1, `TBLP_IDX_A_DIR, ra);
      bus(1, `TBLP_IDX_B_DIR, rb);
      repeat (2) @(posedge CLK_SYS);
      chk(LED_ONE_OUT, da[4]);
      chk(LED_TWO_OUT, db[7]);
      chk(LED_ONE_OE_N, !ra[4]);
      chk(LED_TWO_OE_N, !rb[7]);
      bus(0, `TBLP_IDX_A_DATA, 8'h0);
      chk(q, port_exp(da, ra, 4, LED_ONE_IN));
      bus(0, `TBLP_IDX_B_DATA, 8'h0);
      chk(q, port_exp(db, rb, 7, LED_TWO_IN));
    end
    bus(1, `TBLP_IDX_MODE, 8'h01);
    repeat (300) @(posedge CLK_SYS);
    bus(0, `TBLP_IDX_COUNT, 8'h0);
    chk(q, 0);
    bus(1, `TBLP_IDX_MODE, 8'h19);
    bus(1, `TBLP_IDX_IRQ_EN, 8'h40);
    bus(1, `TBLP_IDX_IRQ_REQ, 8'h40);
    bus(0, `TBLP_IDX_IRQ_REQ, 8'h0);
    chk(q, 0);
    repeat (300) @(posedge CLK_SYS);
    bus(0, `TBLP_IDX_COUNT, 8'h0);
    chk(q >= 3 && q <= 6, 1);
    for (n = 0; n < 17000 && TIMER_IRQ !== 1'b1; n++)
      @(posedge CLK_SYS);
    chk(n > 15950 && n < 16200, 1);
    bus(0, `TBLP_IDX_IRQ_REQ, 8'h0);
    chk(q, 32'h40);
    bus(1, `TBLP_IDX_IRQ_EN, 8'h0);
    repeat (2) @(posedge CLK_SYS);
    chk(TIMER_IRQ, 0);
    bus(1, `TBLP_IDX_IRQ_EN, 8'h40);
    repeat (2) @(posedge CLK_SYS);
    chk(TIMER_IRQ, 1);
    bus(1, `TBLP_IDX_IRQ_REQ, 8'h0);
    repeat (2) @(posedge CLK_SYS);
    chk(TIMER_IRQ, 0);
    close_out();
  end
endmodule

bind tblp_top tblp_props #(.PRE_TAP(PRE_TAP)) u_props (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .LED_ONE_OUT(LED_ONE_OUT),
  .LED_TWO_OE_N(LED_TWO_OE_N), .TIMER_IRQ(TIMER_IRQ));
